// File: modbus_crc16.sv
// Shared constants for the serial slave frame checker, and the bit-serial CRC-16 engine.
`timescale 1ns/1ns
`default_nettype none
package modbus_pkg;
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'hA001;
   localparam logic [3:0] CRC_STEPS = 4'h8;
   localparam logic [7:0] FN_READ = 8'h03;
   localparam logic [7:0] FN_WRITE1 = 8'h06;
   localparam logic [7:0] FN_WRITEN = 8'h10;
   localparam logic [7:0] EXC_FLAG = 8'h80;
   localparam logic [7:0] ERR_NONE = 8'h00;
   localparam logic [7:0] ERR_FUNC = 8'h81;
   localparam logic [7:0] ERR_ADDR = 8'h82;
   localparam logic [7:0] ERR_VALUE = 8'h83;
   localparam logic [16:0] READ_LAST = 17'h0_0148;
   localparam logic [16:0] WRITE_LAST = 17'h0_00FF;
   localparam logic [15:0] MAX_REGS = 16'h003C;
   localparam logic [7:0] MIN_FRAME = 8'h04;
   localparam logic [7:0] FIXED_LEN = 8'h08;
   localparam logic [7:0] WRITEN_HDR = 8'h09;
   localparam logic [7:0] IDX_LAST = 8'hFF;
   localparam logic [2:0] EXC_CRC_AT = 3'h3;
   localparam logic [2:0] EXC_LAST = 3'h4;
   localparam longint CLK_HZ = 125000000;
   localparam longint BAUD_DEFAULT = 9600;
   // Inter-frame silence of 3.5 characters of 10 bits, a least time, so it rounds up.
   localparam longint GAP_BITS = 35;
   localparam int GAP_CYCLES_DEFAULT = int'((CLK_HZ * GAP_BITS + BAUD_DEFAULT - 1) / BAUD_DEFAULT);
   localparam int GAP_W = 20;
endpackage

module crc16_engine (
   input wire logic sys_clk, // Core clock.
   input wire logic arst_n, // Asynchronous reset, active low.
   input wire logic init, // Pulse: preset the register.
   input wire logic start, // Pulse: take byte_in and run eight steps.
   input wire logic [7:0] byte_in, // Byte to fold in.
   output logic [15:0] crc, // Running check register.
   output logic busy // High while bit steps remain.
);
   import modbus_pkg::*;
   logic [3:0] steps;

   function automatic logic [15:0] crc_step(input logic [15:0] v);
      logic [15:0] s;
      s = {1'b0, v[15:1]};
      crc_step = v[0] ? (s ^ CRC_POLY) : s;
   endfunction

   assign busy = (steps != 4'h0);

   // Init must not arrive while busy; the caller only presets between bytes.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         crc <= CRC_INIT;
      end else if (init) begin
         crc <= CRC_INIT;
      end else if (start) begin
         crc <= crc ^ {8'h00, byte_in};
      end else if (busy) begin
         crc <= crc_step(crc);
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         steps <= 4'h0;
      end else if (start) begin
         steps <= CRC_STEPS;
      end else if (busy) begin
         steps <= steps - 4'h1;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   property p_init;
      init |=> (crc == CRC_INIT) && !busy;
   endproperty
   a_init: assert property (p_init) else $error("check register not preset to all ones");

   sequence s_eight_steps;
      busy [*8] ##1 !busy;
   endsequence
   property p_eight;
      start |=> s_eight_steps;
   endproperty
   a_eight: assert property (p_eight) else $error("byte did not take exactly eight steps");

   property p_step;
      start ##1 busy |=> crc == crc_step($past(crc));
   endproperty
   a_step: assert property (p_step) else $error("bit step gave wrong register value");
endmodule
`default_nettype wire

// File: modbus_frame_check.sv
// Slave request checker: frame CRC, fault detection and exception replies.
`timescale 1ns/1ns
`default_nettype none
module modbus_frame_check #(
   parameter int GAP_CYCLES = modbus_pkg::GAP_CYCLES_DEFAULT // End-of-frame silence in clocks.
) (
   input wire logic sys_clk, // Core clock, 125 MHz.
   input wire logic arst_n, // Asynchronous reset, active low.
   input wire logic [7:0] own_addr, // Station address of this drive.
   input wire logic rx_valid, // Pulse: a received byte is on rx_data.
   input wire logic [7:0] rx_data, // Received byte.
   output logic tx_valid, // Exception byte is offered.
   input wire logic tx_ready, // Transmitter takes the byte.
   output logic [7:0] tx_data, // Exception byte.
   output logic value_strobe, // Pulse: ask whether value_data fits value_addr.
   output logic [15:0] value_addr, // Parameter being written.
   output logic [15:0] value_data, // Value being written.
   input wire logic value_bad, // Answer in the cycle of value_strobe.
   output logic req_valid, // Pulse: a clean request for the normal reply path.
   output logic [7:0] req_func, // Its function code.
   output logic [15:0] req_addr, // Its start register.
   output logic [15:0] req_count // Its register count, or the value for a single write.
);
   import modbus_pkg::*;
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_RX = 3'b001,
      S_CHECK = 3'b010,
      S_XCRC = 3'b011,
      S_XSEND = 3'b100
   } state_e;

   localparam logic [GAP_W-1:0] GAP_LAST = GAP_W'(GAP_CYCLES - 1);

   state_e state;
   logic [7:0] idx, hist0, hist1, station, func, byte_cnt, err_code, crc_byte;
   logic [15:0] start_addr, qty, reg_ptr, crc, word_in;
   logic [GAP_W-1:0] gap;
   logic [2:0] xi;
   logic reply_ok, crc_init, crc_start, crc_busy, rx_take, decide, crc_match, frame_good, len_ok, tx_fire;
   logic [16:0] range_end;

   function automatic logic fn_known(input logic [7:0] f);
      fn_known = (f == FN_READ) || (f == FN_WRITE1) || (f == FN_WRITEN);
   endfunction

   function automatic logic [7:0] exc_byte(input logic [2:0] i, input logic [7:0] st, input logic [7:0] fn,
                                           input logic [7:0] ec, input logic [15:0] c);
      unique case (i)
         3'h0: exc_byte = st;
         3'h1: exc_byte = fn | EXC_FLAG;
         3'h2: exc_byte = ec;
         3'h3: exc_byte = c[7:0];
         default: exc_byte = c[15:8];
      endcase
   endfunction

   assign rx_take = rx_valid && ((state == S_IDLE) || (state == S_RX));
   assign decide = (state == S_CHECK) && !crc_busy && !value_strobe;
   // Received code goes out low byte first, so the swapped register must equal the two last bytes in order.
   assign crc_match = ({crc[7:0], crc[15:8]} == {hist1, hist0});
   assign frame_good = crc_match && (idx >= MIN_FRAME) && (station == own_addr);
   assign len_ok = (func == FN_WRITEN) ? (idx == (WRITEN_HDR + byte_cnt)) : (idx == FIXED_LEN);
   assign tx_fire = tx_valid && tx_ready;
   assign word_in = {hist0, rx_data};
   assign range_end = {1'b0, start_addr} + {1'b0, word_in} - 17'h0_0001;

   // Bytes are fed two behind the line so the trailing check code never enters the register.
   always_comb begin
      crc_init = 1'b0;
      crc_start = 1'b0;
      crc_byte = hist1;
      if (rx_take && (state == S_IDLE)) begin
         crc_init = 1'b1;
      end else if (rx_take && (idx >= 8'h02)) begin
         crc_start = 1'b1;
      end else if (decide && frame_good && (err_code != ERR_NONE)) begin
         crc_init = 1'b1;
      end else if ((state == S_XCRC) && !crc_busy && (xi != EXC_CRC_AT)) begin
         crc_start = 1'b1;
         crc_byte = exc_byte(xi, station, func, err_code, crc);
      end
   end

   crc16_engine u_crc (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .init(crc_init),
      .start(crc_start),
      .byte_in(crc_byte),
      .crc(crc),
      .busy(crc_busy)
   );

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= S_IDLE;
      end else begin
         unique case (state)
            S_IDLE: if (rx_take) state <= S_RX;
            S_RX: if (!rx_valid && (gap == GAP_LAST)) state <= S_CHECK;
            S_CHECK: begin
               if (decide) begin
                  // A bad check code, a foreign address or a runt ends here without a reply.
                  state <= (frame_good && (err_code != ERR_NONE)) ? S_XCRC : S_IDLE;
               end
            end
            S_XCRC: if (!crc_busy && (xi == EXC_CRC_AT)) state <= S_XSEND;
            S_XSEND: if (tx_fire && (xi == EXC_LAST)) state <= S_IDLE;
            default: state <= S_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         gap <= '0;
      end else if ((state != S_RX) || rx_valid) begin
         gap <= '0;
      end else begin
         gap <= gap + GAP_W'(1);
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         idx <= 8'h00;
         hist0 <= 8'h00;
         hist1 <= 8'h00;
      end else if (rx_take) begin
         idx <= (state == S_IDLE) ? 8'h01 : ((idx == IDX_LAST) ? IDX_LAST : idx + 8'h01);
         hist0 <= rx_data;
         hist1 <= hist0;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         station <= 8'h00;
         func <= 8'h00;
         start_addr <= 16'h0000;
         qty <= 16'h0000;
         byte_cnt <= 8'h00;
      end else if (rx_take) begin
         if (state == S_IDLE) station <= rx_data;
         unique case (idx)
            8'h01: func <= rx_data;
            8'h03: start_addr <= word_in;
            8'h05: qty <= word_in;
            8'h06: byte_cnt <= rx_data;
            default: ;
         endcase
      end
   end

   // The first fault found is kept; fields arrive in the order function, address, value.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         err_code <= ERR_NONE;
      end else if (rx_take && (state == S_IDLE)) begin
         err_code <= ERR_NONE;
      end else if (err_code == ERR_NONE) begin
         if (value_strobe && value_bad) begin
            err_code <= ERR_VALUE;
         end else if (rx_take && (idx == 8'h01) && !fn_known(rx_data)) begin
            err_code <= ERR_FUNC;
         end else if (rx_take && (idx == 8'h03) && (func == FN_WRITE1) && ({1'b0, word_in} > WRITE_LAST)) begin
            err_code <= ERR_ADDR;
         end else if (rx_take && (idx == 8'h05) && (func != FN_WRITE1)) begin
            if ((word_in == 16'h0000) || (word_in > MAX_REGS)) begin
               err_code <= ERR_VALUE;
            end else if (range_end > ((func == FN_READ) ? READ_LAST : WRITE_LAST)) begin
               err_code <= ERR_ADDR;
            end
         end else if (rx_take && (idx == 8'h06) && (func == FN_WRITEN) && (rx_data != {qty[6:0], 1'b0})) begin
            err_code <= ERR_VALUE;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         value_strobe <= 1'b0;
         value_addr <= 16'h0000;
         value_data <= 16'h0000;
         reg_ptr <= 16'h0000;
      end else begin
         value_strobe <= 1'b0;
         if (rx_take && (idx == 8'h03)) reg_ptr <= word_in;
         // Stale counters from the previous frame must not raise a strobe on a first byte.
         if (rx_take && (state == S_RX) && (err_code == ERR_NONE) && !(value_strobe && value_bad)) begin
            if ((func == FN_WRITE1) && (idx == 8'h05)) begin
               value_strobe <= 1'b1;
               value_addr <= start_addr;
               value_data <= word_in;
            end else if ((func == FN_WRITEN) && (idx >= 8'h08) && !idx[0] && (idx <= byte_cnt + 8'h06)) begin
               value_strobe <= 1'b1;
               value_addr <= reg_ptr;
               value_data <= word_in;
               reg_ptr <= reg_ptr + 16'h0001;
            end
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         xi <= 3'h0;
      end else if (decide) begin
         xi <= 3'h0;
      end else if (crc_start && (state == S_XCRC)) begin
         xi <= xi + 3'h1;
      end else if ((state == S_XCRC) && !crc_busy && (xi == EXC_CRC_AT)) begin
         xi <= 3'h0;
      end else if ((state == S_XSEND) && tx_fire) begin
         xi <= xi + 3'h1;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_valid <= 1'b0;
         tx_data <= 8'h00;
      end else if ((state == S_XCRC) && !crc_busy && (xi == EXC_CRC_AT)) begin
         tx_valid <= 1'b1;
         tx_data <= exc_byte(3'h0, station, func, err_code, crc);
      end else if ((state == S_XSEND) && tx_fire) begin
         if (xi == EXC_LAST) begin
            tx_valid <= 1'b0;
         end else begin
            tx_data <= exc_byte(xi + 3'h1, station, func, err_code, crc);
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         req_valid <= 1'b0;
         req_func <= 8'h00;
         req_addr <= 16'h0000;
         req_count <= 16'h0000;
         reply_ok <= 1'b0;
      end else begin
         req_valid <= decide && frame_good && (err_code == ERR_NONE) && len_ok;
         if (decide) begin
            req_func <= func;
            req_addr <= start_addr;
            req_count <= qty;
            reply_ok <= frame_good;
         end
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   property p_no_reply;
      $rose(tx_valid) |-> reply_ok && (err_code != ERR_NONE);
   endproperty
   a_no_reply: assert property (p_no_reply) else $error("reply started for a discarded frame");

   property p_reply;
      decide && frame_good && (err_code != ERR_NONE) |-> ##[28:32] $rose(tx_valid);
   endproperty
   a_reply: assert property (p_reply) else $error("faulty request got no exception reply");

   property p_flag;
      tx_valid && (xi == 3'h1) |-> (tx_data == (func | EXC_FLAG)) && tx_data[7];
   endproperty
   a_flag: assert property (p_flag) else $error("function code in reply lacks top bit");

   sequence s_first_byte;
      $rose(tx_valid) && (tx_data == station);
   endsequence
   property p_station;
      $rose(tx_valid) |-> s_first_byte;
   endproperty
   a_station: assert property (p_station) else $error("reply does not open with the station address");

   property p_func_err;
      (state == S_XCRC) && !fn_known(func) |-> err_code == ERR_FUNC;
   endproperty
   a_func_err: assert property (p_func_err) else $error("unsupported function not reported as 81");

   property p_value_err;
      value_strobe && value_bad && (err_code == ERR_NONE) |=> (err_code == ERR_VALUE) [*2];
   endproperty
   a_value_err: assert property (p_value_err) else $error("bad value not reported as 83");
endmodule
`default_nettype wire

// File: modbus_host_model.sv
// Behavioural serial host that sends request frames and collects exception replies.
`timescale 1ns/1ns
`default_nettype none
module modbus_host_model (
   input wire logic sys_clk, // Core clock.
   input wire logic arst_n, // Reset, active low.
   output logic rx_valid, // Byte strobe toward the slave.
   output logic [7:0] rx_data, // Byte toward the slave.
   input wire logic tx_valid, // Reply byte offered.
   input wire logic [7:0] tx_data, // Reply byte.
   output logic tx_ready // Reply byte taken.
);
   typedef logic [7:0] bytes_t[$];
   bytes_t got;
   bit stall = 1'b0;
   initial begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      tx_ready = 1'b1;
   end
   function automatic logic [15:0] crc_of(input bytes_t f);
      logic [15:0] c;
      c = 16'hFFFF;
      foreach (f[i]) begin
         c = c ^ {8'h00, f[i]};
         for (int k = 0; k < 8; k++) begin
            c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
         end
      end
      return c;
   endfunction
   // Twelve clocks per byte keeps the run short; the slave needs at least nine to finish its bit steps.
   task automatic send(input bytes_t f, input bit bad);
      logic [15:0] c;
      c = crc_of(f) ^ {15'h0000, bad};
      f.push_back(c[7:0]);
      f.push_back(c[15:8]);
      foreach (f[i]) begin
         @(negedge sys_clk);
         rx_valid = 1'b1;
         rx_data = f[i];
         @(negedge sys_clk);
         rx_valid = 1'b0;
         rx_data = ~f[i];
         repeat (10) @(negedge sys_clk);
      end
   endtask
   always @(negedge sys_clk) tx_ready <= stall ? 1'($urandom_range(1, 0)) : 1'b1;
   always @(posedge sys_clk) if (arst_n && tx_valid && tx_ready) got.push_back(tx_data);
endmodule
`default_nettype wire

// File: tb.sv
// Self-checking testbench for the slave request checker.
`timescale 1ns/1ns
`default_nettype none
module tb;
   import modbus_pkg::*;
   typedef logic [7:0] bytes_t[$];
   localparam int GAP = 40;
   logic sys_clk, arst_n, value_bad, rx_valid, tx_valid, tx_ready, value_strobe, req_valid;
   logic [7:0] own_addr, rx_data, tx_data, req_func;
   logic [15:0] value_addr, value_data, req_addr, req_count, a, q, va, vd;
   int bad_count = 0;
   int checks = 0;
   int reqs = 0;
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   modbus_frame_check #(.GAP_CYCLES(GAP)) uut (.sys_clk(sys_clk), .arst_n(arst_n), .own_addr(own_addr),
      .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
      .value_strobe(value_strobe), .value_addr(value_addr), .value_data(value_data), .value_bad(value_bad),
      .req_valid(req_valid), .req_func(req_func), .req_addr(req_addr), .req_count(req_count));
   modbus_host_model host (.sys_clk(sys_clk), .arst_n(arst_n), .rx_valid(rx_valid), .rx_data(rx_data),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
   // The parameter owner refuses any written value above this limit.
   always @(negedge sys_clk) value_bad <= value_strobe && (value_data > 16'h1000);
   always @(posedge sys_clk) if (req_valid === 1'b1) reqs++;
   always @(posedge sys_clk) if (value_strobe === 1'b1) {va, vd} = {value_addr, value_data};
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   function automatic logic [7:0] exp_read(input logic [15:0] ad, input logic [15:0] n);
      if (n == 16'h0000 || n > 16'h003C) return 8'h83;
      if (32'(ad) + 32'(n) - 1 > 32'h0000_0148) return 8'h82;
      return 8'h00;
   endfunction
   function automatic bytes_t wr_n(input logic [15:0] ad, input logic [15:0] n, input logic [7:0] bc,
                                   input logic [15:0] d0, input logic [15:0] d1);
      return '{own_addr, 8'h10, ad[15:8], ad[7:0], n[15:8], n[7:0], bc, d0[15:8], d0[7:0], d1[15:8], d1[7:0]};
   endfunction
   // A silent frame gets neither a request nor a reply; a nonzero code expects a five-byte exception reply.
   task automatic run(input bytes_t f, input bit bad, input bit silent, input logic [7:0] err, input string name);
      int r0;
      int w;
      bytes_t e;
      logic [15:0] c;
      r0 = reqs;
      host.got.delete();
      host.send(f, bad);
      w = 0;
      while (w < GAP + 300 && host.got.size() < 5 && reqs == r0) begin
         @(negedge sys_clk);
         w++;
      end
      repeat (4) @(negedge sys_clk);
      if (silent || err !== 8'h00) chk(32'(reqs - r0), 0, "unexpected request");
      else begin
         chk(32'(reqs - r0), 1, "request count");
         chk({24'h0, req_func}, {24'h0, f[1]}, "function");
         chk({req_addr, req_count}, {f[2], f[3], f[4], f[5]}, "address and count");
      end
      if (silent || err === 8'h00) chk(32'(host.got.size()), 0, "unexpected reply");
      else begin
         e = '{f[0], f[1] | 8'h80, err};
         c = host.crc_of(e);
         e.push_back(c[7:0]);
         e.push_back(c[15:8]);
         chk(32'(host.got.size()), 5, "reply length");
         for (int i = 0; i < 5 && i < host.got.size(); i++) begin
            chk({24'h0, host.got[i]}, {24'h0, e[i]}, "reply byte");
         end
      end
      $display("test %s done", name);
   endtask
   initial begin
      repeat (40000) @(posedge sys_clk);
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      bad_count++;
      finish_test();
   end
   initial begin
      bytes_t bad_fn;
      bad_fn = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h05, 8'h07, 8'h0F, 8'h11, 8'h83, 8'hFF};
      arst_n = 1'b0;
      void'($urandom(32'hc9f6));
      own_addr = 8'($urandom_range(247, 1));
      repeat (16) @(negedge sys_clk);
      arst_n = 1'b1;
      run('{own_addr, 8'h03, 8'h00, 8'h09, 8'h00, 8'h02}, 0, 0, 8'h00, "read");
      run('{own_addr, 8'h06, 8'h00, 8'h2C, 8'h07, 8'hD0}, 0, 0, 8'h00, "write one");
      chk({va, vd}, 32'h002C_07D0, "written word");
      run(wr_n(16'h002C, 16'h0002, 8'h04, 16'h0064, 16'h0010), 0, 0, 8'h00, "write many");
      chk({va, vd}, 32'h002D_0010, "last written word");
      run('{own_addr, 8'h03, 8'h00, 8'h09, 8'h00, 8'h02}, 1, 1, 8'h00, "bad check code");
      run('{own_addr, 8'h04, 8'h00, 8'h09, 8'h00, 8'h02}, 1, 1, 8'h00, "bad code and check");
      run('{own_addr + 8'h01, 8'h03, 8'h00, 8'h09, 8'h00, 8'h02}, 0, 1, 8'h00, "other station");
      foreach (bad_fn[i]) run('{own_addr, bad_fn[i], 8'h00, 8'h00, 8'h00, 8'h01}, 0, 0, 8'h81, "function");
      host.stall = 1'b1;
      run('{own_addr, 8'h03, 8'h01, 8'h48, 8'h00, 8'h01}, 0, 0, 8'h00, "last readable");
      run('{own_addr, 8'h03, 8'h01, 8'h48, 8'h00, 8'h02}, 0, 0, 8'h82, "read past end");
      run('{own_addr, 8'h06, 8'h01, 8'h00, 8'h00, 8'h01}, 0, 0, 8'h82, "write one past end");
      run(wr_n(16'h00FF, 16'h0002, 8'h04, 16'h0001, 16'h0002), 0, 0, 8'h82, "write many past end");
      run('{own_addr, 8'h06, 8'h00, 8'h04, 8'h20, 8'h00}, 0, 0, 8'h83, "write one value");
      run(wr_n(16'h0009, 16'h0002, 8'h04, 16'h0005, 16'h1001), 0, 0, 8'h83, "write many value");
      run(wr_n(16'h0009, 16'h0002, 8'h03, 16'h0005, 16'h0004), 0, 0, 8'h83, "byte count");
      run('{own_addr, 8'h03, 8'h00, 8'h00, 8'h00, 8'h3D}, 0, 0, 8'h83, "too many");
      run('{own_addr, 8'h03, 8'h00, 8'h00, 8'h00, 8'h3C}, 0, 0, 8'h00, "sixty");
      for (int i = 0; i < 16; i++) begin
         a = 16'($urandom_range(16'h0150, 0));
         q = 16'($urandom_range(64, 0));
         run('{own_addr, 8'h03, a[15:8], a[7:0], q[15:8], q[7:0]}, 0, 0, exp_read(a, q), "random read");
      end
      finish_test();
   end
endmodule
`default_nettype wire
